// ==== design/dbgp_bus_if.sv ====
`default_nettype none
interface dbgp_bus_if;
  logic [7:0] bus_addr;
  logic bus_write_strobe;
  logic bus_read_strobe;
  logic [7:0] bus_write_data;
  logic [7:0] bus_read_data;
  modport master (
    output bus_addr,
    output bus_write_strobe,
    output bus_read_strobe,
    output bus_write_data,
    input bus_read_data
  );
  modport periph (
    input bus_addr,
    input bus_write_strobe,
    input bus_read_strobe,
    input bus_write_data,
    output bus_read_data
  );
endinterface
`default_nettype wire

// ==== design/dbgp_master.sv ====
`default_nettype none
module dbgp_master (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_rst,
  // user request, one-cycle start pulse
  input wire logic i_start,
  input wire logic i_write,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  // user answer
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  // data memory bus
  dbgp_bus_if.master bus
);
  dbgp_pkg::dbgp_cmd_t state_ff;
  logic [7:0] addr_ff;
  logic [7:0] wdata_ff;
  logic done_ff;
  logic busy_ff;
  logic [7:0] rdata_ff;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= dbgp_pkg::DBGP_CMD_IDLE;
    end else if (i_rst) begin
      state_ff <= dbgp_pkg::DBGP_CMD_IDLE;
    end else begin
      case (state_ff)
        dbgp_pkg::DBGP_CMD_IDLE: begin
          if (i_start) begin
            state_ff <= i_write ? dbgp_pkg::DBGP_CMD_WRITE
                                : dbgp_pkg::DBGP_CMD_READ;
          end
        end
        // strobe stands exactly one cycle
        default: state_ff <= dbgp_pkg::DBGP_CMD_IDLE;
      endcase
    end
  end

  // address and data held stable across the strobe cycle
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      addr_ff <= dbgp_pkg::DATA_ZERO;
      wdata_ff <= dbgp_pkg::DATA_ZERO;
    end else if (state_ff == dbgp_pkg::DBGP_CMD_IDLE && i_start) begin
      addr_ff <= i_addr;
      wdata_ff <= i_wdata;
    end
  end

  // busy tracks a non-idle state but comes from its own flop
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_ff <= 1'b0;
    end else if (i_rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= state_ff == dbgp_pkg::DBGP_CMD_IDLE && i_start;
    end
  end

  // read data captured at the strobe cycle's closing edge
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      done_ff <= 1'b0;
      rdata_ff <= dbgp_pkg::DATA_ZERO;
    end else begin
      done_ff <= state_ff != dbgp_pkg::DBGP_CMD_IDLE;
      if (state_ff == dbgp_pkg::DBGP_CMD_READ) begin
        rdata_ff <= bus.bus_read_data;
      end
    end
  end

  assign bus.bus_addr = addr_ff;
  assign bus.bus_write_data = wdata_ff;
  assign bus.bus_write_strobe = state_ff == dbgp_pkg::DBGP_CMD_WRITE;
  assign bus.bus_read_strobe = state_ff == dbgp_pkg::DBGP_CMD_READ;
  assign o_busy = busy_ff;
  assign o_done = done_ff;
  assign o_rdata = rdata_ff;
endmodule
`default_nettype wire

// ==== design/dbgp_periph.sv ====
`default_nettype none
module dbgp_periph #(
  parameter logic [7:0] OUT_BASE = dbgp_pkg::OUT_BASE_DEF,
  parameter logic [7:0] IN_BASE = dbgp_pkg::IN_BASE_DEF,
  parameter logic [7:0] BTN_BASE = dbgp_pkg::BTN_BASE_DEF
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // documented active-high reset
  input wire logic i_rst,
  // data memory bus
  dbgp_bus_if.periph bus,
  // pins
  input wire logic [7:0] i_gpio_in,
  // pins already cleaned by a debouncer outside this block
  input wire logic [7:0] i_btn_in,
  output logic [7:0] o_gpio_out
);
  function automatic logic win_sel(input logic [7:0] addr,
                                   input logic [7:0] base,
                                   input int unsigned nbits);
    return (addr >> nbits) == (base >> nbits);
  endfunction

  // low-address match inside a window of 2^nbits bytes
  function automatic logic ofs_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs,
                                   input int unsigned nbits);
    logic [7:0] mask;
    mask = 8'hff >> (dbgp_pkg::ADDR_W - nbits);
    if (nbits == 0) begin
      mask = dbgp_pkg::DATA_ZERO;
    end
    return (addr & mask) == (ofs & mask);
  endfunction

  logic out_sel;
  logic in_sel;
  logic btn_sel;
  logic mem_sel;
  logic out_wr;
  logic out_rd;
  logic in_rd;
  logic btn_rd;
  logic mem_wr;
  logic mem_rd;
  logic [7:0] out_latch;
  logic [7:0] in_sample;
  logic [7:0] btn_sample;
  logic [7:0] mem_word;
  logic [7:0] out_rdata;
  logic [7:0] in_rdata;
  logic [7:0] btn_rdata;
  logic [7:0] mem_rdata;
  logic [6:0] mem_addr;

  assign out_sel = win_sel(bus.bus_addr, OUT_BASE, dbgp_pkg::REG_WIN_BITS);
  assign in_sel = win_sel(bus.bus_addr, IN_BASE, dbgp_pkg::REG_WIN_BITS);
  assign btn_sel = win_sel(bus.bus_addr, BTN_BASE, dbgp_pkg::BTN_WIN_BITS);
  assign mem_sel = bus.bus_addr[dbgp_pkg::MEM_SEL_BIT] == dbgp_pkg::MEM_SEL_VAL;
  assign mem_addr = bus.bus_addr[dbgp_pkg::MEM_AW-1:0];

  assign out_wr = out_sel & bus.bus_write_strobe
    & ofs_hit(bus.bus_addr, dbgp_pkg::OUT_LATCH_OFS, dbgp_pkg::REG_WIN_BITS);
  assign mem_wr = mem_sel & bus.bus_write_strobe;
  assign out_rd = out_sel & bus.bus_read_strobe
    & ofs_hit(bus.bus_addr, dbgp_pkg::OUT_LATCH_OFS, dbgp_pkg::REG_WIN_BITS);
  assign in_rd = in_sel & bus.bus_read_strobe
    & ofs_hit(bus.bus_addr, dbgp_pkg::IN_SAMPLE_OFS, dbgp_pkg::REG_WIN_BITS);
  // other offsets of this window hold no register and read zero
  assign btn_rd = btn_sel & bus.bus_read_strobe
    & ofs_hit(bus.bus_addr, dbgp_pkg::BTN_DATA_OFS, dbgp_pkg::BTN_WIN_BITS);
  assign mem_rd = mem_sel & bus.bus_read_strobe;

  dbgp_out_latch u_dbgp_out_latch (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_rst(i_rst),
    .i_wr(out_wr),
    .i_wdata(bus.bus_write_data),
    .o_latch(out_latch)
  );

  assign o_gpio_out = out_latch;

  // pins are asynchronous: two stages before use
  dbgp_pin_sync u_dbgp_pin_sync_gpio (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_rst(i_rst),
    .i_pins(i_gpio_in),
    .o_sample(in_sample)
  );

  // no debouncing or change flags here: only the data register
  dbgp_pin_sync u_dbgp_pin_sync_btn (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_rst(i_rst),
    .i_pins(i_btn_in),
    .o_sample(btn_sample)
  );

  dbgp_data_mem u_dbgp_data_mem (
    .i_ref_clk(i_ref_clk),
    .i_wr(mem_wr),
    .i_addr(mem_addr),
    .i_wdata(bus.bus_write_data),
    .o_rdata(mem_word)
  );

  assign out_rdata = out_rd ? out_latch : dbgp_pkg::DATA_ZERO;
  assign in_rdata = in_rd ? in_sample : dbgp_pkg::DATA_ZERO;
  assign btn_rdata = btn_rd ? btn_sample : dbgp_pkg::DATA_ZERO;
  assign mem_rdata = mem_rd ? mem_word : dbgp_pkg::DATA_ZERO;
  assign bus.bus_read_data = out_rdata | in_rdata | btn_rdata | mem_rdata;
endmodule

// output latch; its value is both the pin drive and the readback
module dbgp_out_latch (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_rst,
  // decoded write
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  // latched value
  output logic [7:0] o_latch
);
  logic [7:0] latch_ff;

  // either reset clears it
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      latch_ff <= dbgp_pkg::OUT_LATCH_RST;
    end else if (i_rst) begin
      latch_ff <= dbgp_pkg::OUT_LATCH_RST;
    end else if (i_wr) begin
      latch_ff <= i_wdata;
    end
  end

  assign o_latch = latch_ff;
endmodule

// two-stage synchroniser for asynchronous pins
module dbgp_pin_sync (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_rst,
  // raw pins in, settled sample out
  input wire logic [7:0] i_pins,
  output logic [7:0] o_sample
);
  logic [7:0] meta_ff;
  logic [7:0] sample_ff;

  // only sample_ff is read: meta_ff may still be settling
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_ff <= dbgp_pkg::IN_SAMPLE_RST;
      sample_ff <= dbgp_pkg::IN_SAMPLE_RST;
    end else if (i_rst) begin
      meta_ff <= dbgp_pkg::IN_SAMPLE_RST;
      sample_ff <= dbgp_pkg::IN_SAMPLE_RST;
    end else begin
      meta_ff <= i_pins;
      sample_ff <= meta_ff;
    end
  end

  assign o_sample = sample_ff;
endmodule

// 128-byte memory; read is asynchronous like distributed ram
module dbgp_data_mem (
  // clock
  input wire logic i_ref_clk,
  // decoded access
  input wire logic i_wr,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  // addressed word
  output logic [7:0] o_rdata
);
  logic [7:0] mem_ff [dbgp_pkg::MEM_DEPTH];

  // no reset: contents survive reset like a block ram
  always_ff @(posedge i_ref_clk) begin
    if (i_wr) begin
      mem_ff[i_addr] <= i_wdata;
    end
  end

  assign o_rdata = mem_ff[i_addr];
endmodule
`default_nettype wire

// ==== design/dbgp_pkg.sv ====
`default_nettype none
package dbgp_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  // output latch and input sample each take a one-byte window
  localparam int unsigned REG_WIN_BITS = 0;
  localparam logic [7:0] OUT_BASE_DEF = 8'h80;
  localparam logic [7:0] IN_BASE_DEF = 8'h81;
  localparam logic [7:0] OUT_LATCH_OFS = 8'h00;
  localparam logic [7:0] IN_SAMPLE_OFS = 8'h00;
  // pre-debounced input: data register only, 4-byte window
  localparam logic [7:0] BTN_BASE_DEF = 8'h84;
  localparam int unsigned BTN_WIN_BITS = 2;
  localparam logic [7:0] BTN_DATA_OFS = 8'h00;
  localparam logic [7:0] OUT_LATCH_RST = 8'h00;
  localparam logic [7:0] IN_SAMPLE_RST = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  // memory: 128 bytes, selected when address msb is 0
  localparam int unsigned MEM_AW = 7;
  localparam int unsigned MEM_DEPTH = 128;
  localparam int unsigned MEM_SEL_BIT = 7;
  localparam logic MEM_SEL_VAL = 1'b0;
  localparam logic [7:0] MEM_INIT = 8'h00;
  typedef enum logic [1:0] {
    DBGP_CMD_IDLE,
    DBGP_CMD_WRITE,
    DBGP_CMD_READ
  } dbgp_cmd_t;
endpackage
`default_nettype wire

// ==== testbench/dbgp_bus_checker.sv ====
`default_nettype none
module dbgp_bus_checker (
  // clock and resets
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_rst,
  // data memory bus
  input wire logic [7:0] bus_addr,
  input wire logic bus_write_strobe,
  input wire logic bus_read_strobe,
  input wire logic [7:0] bus_write_data,
  input wire logic [7:0] bus_read_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] latch_ff, mem_a_ff, mem_d_ff;
  logic mem_v_ff;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      latch_ff <= 8'h00;
      mem_v_ff <= 1'b0;
    end else if (i_rst) begin
      latch_ff <= 8'h00;
    end else if (bus_write_strobe) begin
      if (bus_addr == 8'h80) latch_ff <= bus_write_data;
      if (!bus_addr[7]) mem_v_ff <= 1'b1;
    end
  end
  // memory keeps contents across resets, so no reset here
  always_ff @(posedge i_ref_clk) begin
    if (bus_write_strobe && !bus_addr[7]) begin
      mem_a_ff <= bus_addr;
      mem_d_ff <= bus_write_data;
    end
  end
  idle_read_zero_a:
  assert property (!bus_read_strobe |-> bus_read_data == 8'h00)
    else $error("read data not zero while idle");
  unmapped_zero_a:
  assert property (bus_read_strobe && bus_addr > 8'h81
    && bus_addr != dbgp_pkg::BTN_BASE_DEF |->
    bus_read_data == 8'h00) else $error("unmapped read not zero");
  wr_pulse_a:
  assert property (bus_write_strobe |=> !bus_write_strobe)
    else $error("write strobe too long");
  rd_pulse_a:
  assert property (bus_read_strobe |=> !bus_read_strobe)
    else $error("read strobe too long");
  strobe_excl_a:
  assert property (!(bus_write_strobe && bus_read_strobe))
    else $error("both strobes high");
  latch_back_a:
  assert property (bus_read_strobe && bus_addr == 8'h80 |->
    bus_read_data == latch_ff) else $error("latch readback wrong");
  mem_back_a:
  assert property (bus_read_strobe && mem_v_ff && bus_addr == mem_a_ff
    |-> bus_read_data == mem_d_ff) else $error("memory readback wrong");
  rst_quiet_a:
  assert property (i_rst |=> !bus_write_strobe && !bus_read_strobe)
    else $error("strobe after reset");
endmodule
`default_nettype wire

// ==== testbench/dmem_bus_gpio_peripherals_test.sv ====
`default_nettype none
module dmem_bus_gpio_peripherals_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, rst = 0, start = 0, wr = 0, busy, done;
  logic [7:0] addr = 8'h00, wd = 8'h00, pins = 8'h00, btns = 8'h00, rd, gout;
  logic [7:0] mad [3] = '{8'h00, 8'h40, 8'h7f};
  int err_total = 0, checks_done = 0;
  dbgp_bus_if bus ();
  dbgp_master u_dbgp_master (.i_ref_clk(clk), .i_rstn(rstn), .i_rst(rst),
    .i_start(start), .i_write(wr), .i_addr(addr), .i_wdata(wd),
    .o_busy(busy), .o_done(done), .o_rdata(rd), .bus(bus.master));
  dbgp_periph u_dbgp_periph (.i_ref_clk(clk), .i_rstn(rstn), .i_rst(rst),
    .bus(bus.periph), .i_gpio_in(pins), .i_btn_in(btns), .o_gpio_out(gout));
  dbgp_bus_checker u_dbgp_bus_checker (.i_ref_clk(clk), .i_rstn(rstn),
    .i_rst(rst), .bus_addr(bus.bus_addr),
    .bus_write_strobe(bus.bus_write_strobe),
    .bus_read_strobe(bus.bus_read_strobe),
    .bus_write_data(bus.bus_write_data), .bus_read_data(bus.bus_read_data));
  initial forever #5 clk = ~clk;
  task automatic check(input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic w, input logic [7:0] a, d);
    int n;
    @(negedge clk);
    start = 1;
    wr = w;
    addr = a;
    wd = d;
    @(negedge clk);
    start = 0;
    check({7'h00, busy}, 8'h01);
    n = 0;
    // bounded wait so a stuck master cannot hang the run
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (done !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t no done from master", $time);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic t_mem();
    for (int i = 0; i < 3; i++) op(1, mad[i], ~mad[i]);
    op(1, 8'hff, 8'h11);
    for (int i = 0; i < 3; i++) begin
      op(0, mad[i], 8'h00);
      check(rd, ~mad[i]);
    end
    $display("memory test done");
  endtask
  task automatic t_latch();
    op(1, 8'h80, 8'ha5);
    check(gout, 8'ha5);
    op(1, 8'h81, 8'h3c);
    op(1, 8'h82, 8'hff);
    op(0, 8'h80, 8'h00);
    check(rd, 8'ha5);
    op(0, 8'h82, 8'h00);
    check(rd, 8'h00);
    $display("latch test done");
  endtask
  task automatic t_input();
    for (int i = 0; i < 8; i++) begin
      pins = 8'h01 << i;
      btns = 8'h80 >> i;
      repeat (3) @(negedge clk);
      op(0, 8'h81, 8'h00);
      check(rd, 8'h01 << i);
      op(0, dbgp_pkg::BTN_BASE_DEF, 8'h00);
      check(rd, 8'h80 >> i);
    end
    op(0, dbgp_pkg::BTN_BASE_DEF + 8'h01, 8'h00);
    check(rd, 8'h00);
    $display("input test done");
  endtask
  task automatic t_rst();
    @(negedge clk);
    rst = 1;
    @(negedge clk);
    rst = 0;
    check(gout, 8'h00);
    op(0, 8'h00, 8'h00);
    check(rd, 8'hff);
    $display("reset test done");
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1;
    check(gout, 8'h00);
    t_mem();
    t_latch();
    t_input();
    t_rst();
    print_verdict();
  end
  initial begin
    #20000;
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
